// File: bbc_top.sv
/*
 * buck-boost control: chip enable and bias start-up, output enable,
 * fault turn-off, voltage-select latching, slew-paced target ramp,
 * power-good pin, switch phases, active discharge, apb registers.
 * assumes comparator and fault levels arrive from the analog core on
 * pins, and an apb master on the system clock.
 */
// The implementer's own choices: the APB interface to the registers and the register addresses.
//
// Function
// - after chip enable rises the bias settles for 85 us before enable.
// - chip enable low shuts down and restores the type-O registers.
// - the output runs only with chip enable high and the enable bit 1.
// - over-temperature, supply lockout or overcurrent stop it at once.
// - the select pin is latched as chip enable rises and held through bias and soft-start.
// - after soft-start the target follows the select pin live.
// - upward ramp is 12.5 or 25 mV/us by the ramp-up rate bit.
// - downward ramp is 3.125 or 6.25 mV/us by the ramp-down rate bit.
// - power-good asserts at 90% of target, active high by default.
// - switching runs from a fixed 2.5 MHz period.
// - three switch phases drive the four h-bridge switches.
// - buck periods are phase two then phase three.
// - boost periods are phase one then phase two.
// - with the discharge bit 1 the discharge path is on when disabled.
// - the discharge path is off while enabled or with the bit 0.
// - registers answer only while the interface supply is present.
`timescale 1ns/1ns
module bbc_top #(
  parameter bit PGOOD_ACTIVE_HIGH = 1'b1
) (
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_sys_rst,
  // apb slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic o_pready,
  output logic o_pslverr,
  output logic [31:0] o_prdata,
  // pins and analog status
  input wire bbc_pkg::bbc_pins_t i_pins,
  // power stage
  output logic o_reg_en,
  output logic [6:0] o_vref_code,
  output bbc_pkg::bbc_sw_t o_sw,
  output logic o_discharge,
  // power-good open drain
  output logic o_pgood_o,
  output logic o_pgood_oe_n,
  // interrupt
  output logic o_irq
);
  bbc_pkg::bbc_pins_t pin_s;
  bbc_pkg::bbc_state_t state_reg;
  bbc_pkg::bbc_state_t state_next;
  bbc_pkg::bbc_ctrl_t ctrl_reg;
  logic [6:0] vsel_lo_reg;
  logic [6:0] vsel_hi_reg;
  logic [9:0] bias_cnt_reg;
  logic sel_reg;
  logic [6:0] vref_reg;
  logic [6:0] target;
  logic [5:0] ramp_cnt_reg;
  logic fault;
  logic run;
  logic run_reg;
  logic pgood_reg;
  logic pg_next;
  logic [bbc_pkg::IRQ_W-1:0] irq_stat_reg;
  logic [bbc_pkg::IRQ_W-1:0] irq_mask_reg;
  logic [bbc_pkg::IRQ_W-1:0] irq_set;
  logic pready_reg;
  logic pslverr_reg;
  logic [31:0] prdata_reg;
  logic capture;
  logic done;
  logic wr;
  logic rd;
  logic step_up;
  logic step_dn;
  logic ramp_done;
  logic discharge_reg;

  localparam logic [9:0] BIAS_LAST = 10'(bbc_pkg::BIAS_CYC - 1);

  function automatic logic addr_ok(input logic [7:0] a);
    addr_ok = a == bbc_pkg::ADDR_CTRL || a == bbc_pkg::ADDR_VSEL_LO ||
              a == bbc_pkg::ADDR_VSEL_HI || a == bbc_pkg::ADDR_STATUS ||
              a == bbc_pkg::ADDR_IRQ_STAT || a == bbc_pkg::ADDR_IRQ_MASK;
  endfunction : addr_ok

  // clocks per 12.5 mV step at the chosen rate
  function automatic logic [5:0] step_cyc(input logic up, input logic fast);
    if (up) begin
      step_cyc = fast ? bbc_pkg::RU_FAST_CYC : bbc_pkg::RU_SLOW_CYC;
    end else begin
      step_cyc = fast ? bbc_pkg::RD_FAST_CYC : bbc_pkg::RD_SLOW_CYC;
    end
  endfunction : step_cyc

  bbc_sync u_sync (
    .i_mclk(i_mclk),
    .i_sys_rst(i_sys_rst),
    .i_pins(i_pins),
    .o_pins(pin_s)
  );

  //////////////////////////////////////////////////////////////////////////
  // start-up sequence
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      bbc_pkg::ST_OFF: begin
        if (pin_s.chip_en) begin
          state_next = bbc_pkg::ST_BIAS;
        end
      end
      bbc_pkg::ST_BIAS: begin
        if (bias_cnt_reg == BIAS_LAST) begin
          state_next = bbc_pkg::ST_SOFT;
        end
      end
      bbc_pkg::ST_SOFT: begin
        if (run && vref_reg == target) begin
          state_next = bbc_pkg::ST_ON;
        end
      end
      default: begin
        state_next = bbc_pkg::ST_ON;
      end
    endcase
    if (!pin_s.chip_en) begin
      state_next = bbc_pkg::ST_OFF;
    end
  end

  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      state_reg <= bbc_pkg::ST_OFF;
    end else begin
      state_reg <= state_next;
    end
  end

  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      bias_cnt_reg <= 10'h000;
    end else if (state_reg == bbc_pkg::ST_BIAS) begin
      bias_cnt_reg <= bias_cnt_reg + 10'h001;
    end else begin
      bias_cnt_reg <= 10'h000;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // enable, faults and discharge
  assign fault = pin_s.over_temp | pin_s.sys_uvlo | pin_s.over_current;
  // a fault drops the output without waiting for any sequence
  assign run = pin_s.chip_en && ctrl_reg.output_enable_bit && !fault &&
               (state_reg == bbc_pkg::ST_SOFT || state_reg == bbc_pkg::ST_ON);

  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      run_reg <= 1'b0;
      discharge_reg <= 1'b0;
    end else begin
      run_reg <= run;
      discharge_reg <= ctrl_reg.active_discharge_bit && !run;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // voltage select and target ramp
  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      sel_reg <= 1'b0;
    end else if (state_reg == bbc_pkg::ST_OFF && pin_s.chip_en) begin
      sel_reg <= pin_s.voltage_select_pin;
    end else if (state_reg == bbc_pkg::ST_ON) begin
      sel_reg <= pin_s.voltage_select_pin;
    end
  end

  assign target = sel_reg ? vsel_hi_reg : vsel_lo_reg;
  assign step_up = run && ramp_cnt_reg == 6'h00 && vref_reg < target;
  assign step_dn = run && ramp_cnt_reg == 6'h00 && vref_reg > target;
  assign ramp_done = (step_up && vref_reg + 7'h01 == target) ||
                     (step_dn && vref_reg - 7'h01 == target);

  // the reference walks one code at a time; disabling restarts from zero
  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      vref_reg <= 7'h00;
    end else if (!run) begin
      vref_reg <= 7'h00;
    end else if (step_up) begin
      vref_reg <= vref_reg + 7'h01;
    end else if (step_dn) begin
      vref_reg <= vref_reg - 7'h01;
    end
  end

  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      ramp_cnt_reg <= 6'h00;
    end else if (!run || vref_reg == target) begin
      ramp_cnt_reg <= 6'h00;
    end else if (step_up || step_dn) begin
      ramp_cnt_reg <= step_cyc(step_up, step_up ?
          ctrl_reg.ramp_up_rate_bit : ctrl_reg.ramp_down_rate_bit) - 6'h01;
    end else if (ramp_cnt_reg != 6'h00) begin
      ramp_cnt_reg <= ramp_cnt_reg - 6'h01;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // power good: the comparator trips at 90% of the reference
  assign pg_next = run && pin_s.pg_cmp;

  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      pgood_reg <= 1'b0;
    end else begin
      pgood_reg <= pg_next;
    end
  end

  bbc_pwm u_pwm (
    .i_mclk(i_mclk),
    .i_sys_rst(i_sys_rst),
    .i_run(run_reg),
    .i_vin_gt_vout(pin_s.vin_gt_vout),
    .o_sw(o_sw)
  );

  //////////////////////////////////////////////////////////////////////////
  // apb slave: one wait state, then data and error from flops
  assign capture = i_psel && i_penable && !pready_reg;
  assign done = i_psel && i_penable && pready_reg;
  assign wr = done && i_pwrite && !pslverr_reg;
  assign rd = done && !i_pwrite && !pslverr_reg;

  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= 32'h0000_0000;
    end else begin
      pready_reg <= capture;
      // without the interface supply every access is refused
      pslverr_reg <= capture && (!pin_s.vio_ok || !addr_ok(i_paddr));
      prdata_reg <= 32'h0000_0000;
      if (capture && pin_s.vio_ok) begin
        if (i_paddr == bbc_pkg::ADDR_CTRL) begin
          prdata_reg <= {28'h0000000, ctrl_reg};
        end else if (i_paddr == bbc_pkg::ADDR_VSEL_LO) begin
          prdata_reg <= {25'h0000000, vsel_lo_reg};
        end else if (i_paddr == bbc_pkg::ADDR_VSEL_HI) begin
          prdata_reg <= {25'h0000000, vsel_hi_reg};
        end else if (i_paddr == bbc_pkg::ADDR_STATUS) begin
          prdata_reg[bbc_pkg::ST_STATE_LSB +: 2] <= state_reg;
          prdata_reg[bbc_pkg::ST_REG_EN] <= run_reg;
          prdata_reg[bbc_pkg::ST_PGOOD] <= pgood_reg;
          prdata_reg[bbc_pkg::ST_FAULT] <= fault;
          prdata_reg[bbc_pkg::ST_SEL] <= sel_reg;
          prdata_reg[bbc_pkg::ST_VREF_LSB +: 7] <= vref_reg;
        end else if (i_paddr == bbc_pkg::ADDR_IRQ_STAT) begin
          prdata_reg <= {28'h0000000, irq_stat_reg};
        end else if (i_paddr == bbc_pkg::ADDR_IRQ_MASK) begin
          prdata_reg <= {28'h0000000, irq_mask_reg};
        end
      end
    end
  end

  // type-O registers return to defaults whenever chip enable is low
  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      ctrl_reg <= bbc_pkg::CTRL_RST;
      vsel_lo_reg <= bbc_pkg::VSEL_LO_RST;
      vsel_hi_reg <= bbc_pkg::VSEL_HI_RST;
    end else if (!pin_s.chip_en) begin
      ctrl_reg <= bbc_pkg::CTRL_RST;
      vsel_lo_reg <= bbc_pkg::VSEL_LO_RST;
      vsel_hi_reg <= bbc_pkg::VSEL_HI_RST;
    end else if (wr) begin
      if (i_paddr == bbc_pkg::ADDR_CTRL) begin
        ctrl_reg <= i_pwdata[3:0];
      end else if (i_paddr == bbc_pkg::ADDR_VSEL_LO) begin
        vsel_lo_reg <= i_pwdata[6:0];
      end else if (i_paddr == bbc_pkg::ADDR_VSEL_HI) begin
        vsel_hi_reg <= i_pwdata[6:0];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // interrupts: a read clears only the bits it reported; new events survive
  always_comb begin
    irq_set = '0;
    irq_set[bbc_pkg::IRQ_FAULT] = fault && run_reg;
    irq_set[bbc_pkg::IRQ_PG_RISE] = pg_next && !pgood_reg;
    irq_set[bbc_pkg::IRQ_PG_FALL] = !pg_next && pgood_reg;
    irq_set[bbc_pkg::IRQ_RAMP_DONE] = ramp_done;
  end

  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      irq_stat_reg <= '0;
      irq_mask_reg <= '0;
      o_irq <= 1'b0;
    end else begin
      if (rd && i_paddr == bbc_pkg::ADDR_IRQ_STAT) begin
        irq_stat_reg <= (irq_stat_reg & ~prdata_reg[bbc_pkg::IRQ_W-1:0]) |
                        irq_set;
      end else begin
        irq_stat_reg <= irq_stat_reg | irq_set;
      end
      if (wr && i_paddr == bbc_pkg::ADDR_IRQ_MASK) begin
        irq_mask_reg <= i_pwdata[bbc_pkg::IRQ_W-1:0];
      end
      o_irq <= |(irq_stat_reg & irq_mask_reg);
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // outputs
  assign o_pready = pready_reg;
  assign o_pslverr = pslverr_reg;
  assign o_prdata = prdata_reg;
  assign o_reg_en = run_reg;
  assign o_vref_code = vref_reg;
  assign o_discharge = discharge_reg;
  assign o_pgood_o = 1'b0;
  // open drain: released means high on the board
  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_pgood_oe_n <= 1'b0;
    end else begin
      o_pgood_oe_n <= PGOOD_ACTIVE_HIGH ? pg_next : !pg_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_sys_rst);

  bias_wait_a: assert property ($rose(state_reg == bbc_pkg::ST_SOFT)
      |-> $past(bias_cnt_reg) == BIAS_LAST)
    else $error("soft-start began before bias settled");
  shutdown_reset_a: assert property (!pin_s.chip_en |=>
      ctrl_reg == bbc_pkg::CTRL_RST && vsel_lo_reg == bbc_pkg::VSEL_LO_RST)
    else $error("registers kept after shutdown");
  enable_and_a: assert property (o_reg_en |->
      $past(pin_s.chip_en) && $past(ctrl_reg.output_enable_bit))
    else $error("output on without pin and bit");
  fault_off_a: assert property (fault |=> !o_reg_en)
    else $error("output on during fault");
  select_hold_a: assert property (state_reg == bbc_pkg::ST_SOFT &&
      $past(state_reg) == bbc_pkg::ST_SOFT |-> $stable(sel_reg))
    else $error("select changed during soft-start");
  select_follow_a: assert property (state_reg == bbc_pkg::ST_ON &&
      $past(state_reg) == bbc_pkg::ST_ON |-> sel_reg ==
      $past(pin_s.voltage_select_pin))
    else $error("select not following pin");
  // a restart after a drop steps at once, so only paced steps count
  up_slow_a: assert property (step_up && !ctrl_reg.ramp_up_rate_bit
      |=> (!step_up || !run_reg) [*8])
    else $error("slow ramp-up stepped too soon");
  down_slow_a: assert property (step_dn && !ctrl_reg.ramp_down_rate_bit
      |=> !step_dn [*8])
    else $error("slow ramp-down stepped too soon");
  pgood_pin_a: assert property (PGOOD_ACTIVE_HIGH && run &&
      pin_s.pg_cmp |=> o_pgood_oe_n)
    else $error("power-good not released");
  discharge_on_a: assert property (!run &&
      ctrl_reg.active_discharge_bit |=> o_discharge)
    else $error("discharge path not connected");
  discharge_off_a: assert property (o_discharge |-> !o_reg_en)
    else $error("discharge while regulating");
  vio_gate_a: assert property (capture && !pin_s.vio_ok |=>
      o_pready && o_pslverr)
    else $error("access accepted without interface supply");
  single_step_a: assert property ($changed(vref_reg) && run_reg && run
      |-> vref_reg == $past(vref_reg) + 7'h01 ||
      vref_reg == $past(vref_reg) - 7'h01)
    else $error("reference jumped");

  startup_c: cover property (state_reg == bbc_pkg::ST_SOFT ##1
      state_reg == bbc_pkg::ST_ON);
  fault_c: cover property (o_reg_en ##1 fault ##1 !o_reg_en);
  irq_c: cover property (o_irq ##[1:50] rd);
endmodule : bbc_top

// File: bbc_pkg.sv
/*
 * shared constants and types of the buck-boost enable, slew and switch
 * control block.
 * assumes a 10 MHz system clock and a 32-bit apb register port.
 */
package bbc_pkg;

  //////////////////////////////////////////////////////////////////////////
  // clock and timing
  localparam int CLK_MHZ = 10;
  localparam int BIAS_SETTLE_US = 85;
  localparam int BIAS_CYC = BIAS_SETTLE_US * CLK_MHZ;
  localparam int SW_FREQ_KHZ = 2500;
  localparam int SW_PERIOD_CYC = CLK_MHZ * 1000 / SW_FREQ_KHZ;
  localparam int SW_HALF_CYC = SW_PERIOD_CYC / 2;
  // one output code is 12.5 mV; rates in uV per us
  localparam int STEP_UV = 12500;
  localparam int RU_SLOW_UV_US = 12500;
  localparam int RU_FAST_UV_US = 25000;
  localparam int RD_SLOW_UV_US = 3125;
  localparam int RD_FAST_UV_US = 6250;
  localparam logic [5:0] RU_SLOW_CYC = 6'(STEP_UV * CLK_MHZ / RU_SLOW_UV_US);
  localparam logic [5:0] RU_FAST_CYC = 6'(STEP_UV * CLK_MHZ / RU_FAST_UV_US);
  localparam logic [5:0] RD_SLOW_CYC = 6'(STEP_UV * CLK_MHZ / RD_SLOW_UV_US);
  localparam logic [5:0] RD_FAST_CYC = 6'(STEP_UV * CLK_MHZ / RD_FAST_UV_US);

  //////////////////////////////////////////////////////////////////////////
  // register map (byte addresses)
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_VSEL_LO = 8'h04;
  localparam logic [7:0] ADDR_VSEL_HI = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h0c;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h10;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h14;

  typedef struct packed {
    logic active_discharge_bit;
    logic ramp_down_rate_bit;
    logic ramp_up_rate_bit;
    logic output_enable_bit;
  } bbc_ctrl_t;

  localparam logic [3:0] CTRL_RST = 4'h9;
  localparam logic [6:0] VSEL_LO_RST = 7'h38;
  localparam logic [6:0] VSEL_HI_RST = 7'h40;

  // interrupt bits
  localparam int IRQ_W = 4;
  localparam int IRQ_FAULT = 0;
  localparam int IRQ_PG_RISE = 1;
  localparam int IRQ_PG_FALL = 2;
  localparam int IRQ_RAMP_DONE = 3;

  // status fields
  localparam int ST_STATE_LSB = 0;
  localparam int ST_REG_EN = 2;
  localparam int ST_PGOOD = 3;
  localparam int ST_FAULT = 4;
  localparam int ST_SEL = 5;
  localparam int ST_VREF_LSB = 8;

  //////////////////////////////////////////////////////////////////////////
  // types
  typedef enum logic [1:0] {
    ST_OFF = 2'b00,
    ST_BIAS = 2'b01,
    ST_SOFT = 2'b10,
    ST_ON = 2'b11
  } bbc_state_t;

  typedef struct packed {
    logic vio_ok;
    logic pg_cmp;
    logic vin_gt_vout;
    logic over_current;
    logic sys_uvlo;
    logic over_temp;
    logic voltage_select_pin;
    logic chip_en;
  } bbc_pins_t;

  typedef struct packed {
    logic input_high_side_switch;
    logic input_low_side_switch;
    logic output_high_side_switch;
    logic output_low_side_switch;
  } bbc_sw_t;

endpackage : bbc_pkg

// File: bbc_sync.sv
/*
 * three-flop pin synchroniser; the output follows once the second and
 * third flops agree.
 * assumes asynchronous pins and the block's single system clock.
 */
`timescale 1ns/1ns
module bbc_sync (
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_sys_rst,
  // pins
  input wire bbc_pkg::bbc_pins_t i_pins,
  output bbc_pkg::bbc_pins_t o_pins
);
  logic [7:0] ff1_reg;
  logic [7:0] ff2_reg;
  logic [7:0] ff3_reg;
  logic [7:0] out_reg;

  // ff1 feeds only ff2
  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      ff1_reg <= 8'h00;
      ff2_reg <= 8'h00;
      ff3_reg <= 8'h00;
    end else begin
      ff1_reg <= i_pins;
      ff2_reg <= ff1_reg;
      ff3_reg <= ff2_reg;
    end
  end

  // a bit only moves when two samples in a row agree
  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      out_reg <= 8'h00;
    end else begin
      out_reg <= (ff2_reg & ~(ff2_reg ^ ff3_reg)) |
                 (out_reg & (ff2_reg ^ ff3_reg));
    end
  end

  assign o_pins = out_reg;
endmodule : bbc_sync

// File: bbc_pwm.sv
/*
 * h-bridge phase sequencer: one switching period per 2.5 MHz cycle,
 * two phases per period picked by buck or boost operation.
 * assumes the analog current loop trims duty around the fixed split.
 */
`timescale 1ns/1ns
module bbc_pwm (
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_sys_rst,
  // control
  input wire logic i_run,
  input wire logic i_vin_gt_vout,
  // switch gates
  output bbc_pkg::bbc_sw_t o_sw
);
  localparam bbc_pkg::bbc_sw_t PH1 = 4'h9;
  localparam bbc_pkg::bbc_sw_t PH2 = 4'ha;
  localparam bbc_pkg::bbc_sw_t PH3 = 4'h6;
  localparam logic [1:0] PER_LAST = 2'(bbc_pkg::SW_PERIOD_CYC - 1);
  localparam logic [1:0] HALF = 2'(bbc_pkg::SW_HALF_CYC);

  logic [1:0] cnt_reg;
  bbc_pkg::bbc_sw_t sw_reg;
  bbc_pkg::bbc_sw_t sw_next;
  logic first_half;

  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      cnt_reg <= 2'h0;
    end else if (!i_run || cnt_reg == PER_LAST) begin
      cnt_reg <= 2'h0;
    end else begin
      cnt_reg <= cnt_reg + 2'h1;
    end
  end

  assign first_half = cnt_reg < HALF;

  always_comb begin
    sw_next = 4'h0;
    if (i_run) begin
      if (i_vin_gt_vout) begin
        sw_next = first_half ? PH2 : PH3;
      end else begin
        sw_next = first_half ? PH1 : PH2;
      end
    end
  end

  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      sw_reg <= 4'h0;
    end else begin
      sw_reg <= sw_next;
    end
  end

  assign o_sw = sw_reg;

  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_sys_rst);

  no_shoot_a: assert property (!(sw_reg.input_high_side_switch &&
      sw_reg.input_low_side_switch) && !(sw_reg.output_high_side_switch &&
      sw_reg.output_low_side_switch))
    else $error("switch leg shoot-through");
  buck_seq_a: assert property ((i_run && i_vin_gt_vout &&
      cnt_reg == 2'h0) ##1 (i_run && i_vin_gt_vout) [*2] |=> sw_reg == PH3)
    else $error("buck period not phase two then three");
  boost_seq_a: assert property ((i_run && !i_vin_gt_vout &&
      cnt_reg == 2'h1) ##1 (i_run && !i_vin_gt_vout) |=> sw_reg == PH2)
    else $error("boost period not phase one then two");
  period_len_a: assert property ($rose(cnt_reg == 2'h0) && i_run
      |-> ##4 cnt_reg == 2'h0 || !$past(i_run))
    else $error("switching period not four clocks");
endmodule : bbc_pwm

// File: bbc_host.sv
/* host model: a processor driving the enable and voltage-select pins.
   assumes commands from the bench on the system clock; levels only. */
`timescale 1ns/1ns
module bbc_host (
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_sys_rst,
  // commands
  input wire logic i_en_cmd,
  input wire logic i_sel_cmd,
  // pins
  output logic o_chip_en,
  output logic o_sel
);
  // both pins have pull-downs, so they rest low while the host is reset
  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      {o_chip_en, o_sel} <= 2'b00;
    end else begin
      {o_chip_en, o_sel} <= {i_en_cmd, i_sel_cmd};
    end
  end
endmodule : bbc_host

// File: bbc_top_bench.sv
/* self-checking bench of bbc_top with apb master and pin drive.
   assumes the bbc_host pin model and the bbc_pkg constants. */
`timescale 1ns/1ns
module bbc_top_bench;
  logic mclk = 1'b0;
  logic sys_rst = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic vio = 1'b0, pg = 1'b0, vgt = 1'b0, oc = 1'b0, uv = 1'b0, ot = 1'b0;
  logic en_cmd = 1'b0, sel_cmd = 1'b0;
  logic en_pin, sel_pin, pready, pslverr, reg_en, dis, pg_o, pg_oe_n, irq, e;
  logic [31:0] prdata, q;
  logic [31:0] rv [3] = '{32'h9, 32'h38, 32'h40};
  logic [6:0] vref, v;
  bbc_pkg::bbc_sw_t sw;
  int failures = 0;
  int num_checks = 0;
  int n, ca, cb;

  bbc_host i_host (.i_mclk(mclk), .i_sys_rst(sys_rst), .i_en_cmd(en_cmd),
    .i_sel_cmd(sel_cmd), .o_chip_en(en_pin), .o_sel(sel_pin));
  bbc_top i_dut (.i_mclk(mclk), .i_sys_rst(sys_rst), .i_psel(psel),
    .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
    .i_pwdata(pwdata), .o_pready(pready), .o_pslverr(pslverr),
    .o_prdata(prdata), .i_pins({vio, pg, vgt, oc, uv, ot, sel_pin, en_pin}),
    .o_reg_en(reg_en), .o_vref_code(vref), .o_sw(sw), .o_discharge(dis),
    .o_pgood_o(pg_o), .o_pgood_oe_n(pg_oe_n), .o_irq(irq));

  //////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] got, exp);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("FAIL %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic end_sim;
    if (failures == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : end_sim

  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge mclk);
    {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
    @(posedge mclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    {q, e} = {prdata, pslverr};
    {psel, penable} <= 2'b00;
    if (n >= 20) failures++;
  endtask : apb

  // cycles per 12.5 mV code at 10 MHz for a rate in uV per us
  function automatic int per_code(input bit up, input bit fast);
    return 125000 / (up ? (fast ? 25000 : 12500) : (fast ? 6250 : 3125));
  endfunction : per_code

  // the pacing counter phase is unknown, so one code of slack each way
  task automatic ramp(input logic [6:0] from, to, input bit fast);
    int d;
    int p;
    d = (to > from) ? to - from : from - to;
    p = per_code(to > from, fast);
    n = 0;
    while (vref !== to && n < 9000) begin
      @(posedge mclk);
      n++;
    end
    chk("ramp time", 32'(n >= p * (d - 1) && n <= p * (d + 1)), 1);
  endtask : ramp

  task automatic wait_en(input logic val);
    while (reg_en !== val && n < 3000) begin
      @(posedge mclk);
      n++;
    end
  endtask : wait_en

  initial begin
    forever #50 mclk = ~mclk;
  end

  // the whole run needs well under 10000 cycles
  initial begin
    #5000000;
    failures++;
    end_sim();
  end

  initial begin
    void'($urandom(32'h4e89e66d));
    repeat (10) @(posedge mclk);
    chk("reset outs", {reg_en, dis, pg_oe_n, irq}, 32'h0);
    sys_rst <= 1'b0;
    apb(1'b0, bbc_pkg::ADDR_CTRL, 32'h0);
    chk("no vio", {q[30:0], e}, 32'h1);
    vio <= 1'b1;
    repeat (4) @(posedge mclk);
    apb(1'b0, 8'h18, 32'h0);
    chk("unmapped", e, 1'b1);
    for (int i = 0; i < 3; i++) begin
      apb(1'b0, 8'(4 * i), 32'h0);
      chk("reset value", q, rv[i]);
    end
    sel_cmd <= 1'b1;
    en_cmd <= 1'b1;
    repeat (100) @(posedge mclk);
    sel_cmd <= 1'b0;
    n = 100;
    wait_en(1'b1);
    chk("bias wait", 32'(n >= 850 && n <= 862), 1);
    ramp(7'h00, 7'h40, 1'b0);
    ramp(7'h40, 7'h38, 1'b0);
    apb(1'b1, bbc_pkg::ADDR_CTRL, 32'hf);
    v = 7'h41 + 7'($urandom % 16);
    apb(1'b1, bbc_pkg::ADDR_VSEL_HI, {25'h0, v});
    sel_cmd <= 1'b1;
    ramp(7'h38, v, 1'b1);
    sel_cmd <= 1'b0;
    ramp(v, 7'h38, 1'b1);
    for (int b = 0; b < 2; b++) begin
      vgt <= b[0];
      repeat (8) @(posedge mclk);
      ca = 0;
      cb = 0;
      repeat (8) begin
        @(posedge mclk);
        ca += int'(sw === (b[0] ? 4'ha : 4'h9));
        cb += int'(sw === (b[0] ? 4'h6 : 4'ha));
      end
      chk("phases", 32'(ca * 16 + cb), 32'h44);
    end
    apb(1'b1, bbc_pkg::ADDR_IRQ_MASK, 32'h0);
    apb(1'b0, bbc_pkg::ADDR_IRQ_STAT, 32'h0);
    pg <= 1'b1;
    repeat (8) @(posedge mclk);
    chk("pgood", {irq, pg_o, pg_oe_n}, 32'h1);
    apb(1'b1, bbc_pkg::ADDR_IRQ_MASK, 32'h2);
    repeat (3) @(posedge mclk);
    chk("irq on", irq, 1'b1);
    apb(1'b0, bbc_pkg::ADDR_IRQ_STAT, 32'h0);
    chk("irq stat", q[1], 1'b1);
    repeat (3) @(posedge mclk);
    chk("irq clear", irq, 1'b0);
    pg <= 1'b0;
    apb(1'b1, bbc_pkg::ADDR_CTRL, 32'h8);
    repeat (4) @(posedge mclk);
    chk("off dis", {reg_en, dis, pg_oe_n}, 32'h2);
    apb(1'b1, bbc_pkg::ADDR_CTRL, 32'h0);
    repeat (4) @(posedge mclk);
    chk("off no dis", dis, 1'b0);
    apb(1'b1, bbc_pkg::ADDR_CTRL, 32'h9);
    wait_en(1'b1);
    repeat (2) @(posedge mclk);
    chk("on no dis", {reg_en, dis}, 32'h2);
    for (int f = 0; f < 3; f++) begin
      {oc, uv, ot} <= 3'(1 << f);
      repeat (7) @(posedge mclk);
      chk("fault off", {reg_en, dis}, 32'h1);
      {oc, uv, ot} <= 3'h0;
      n = 0;
      wait_en(1'b1);
      chk("fault clear", reg_en, 1'b1);
    end
    apb(1'b1, bbc_pkg::ADDR_CTRL, 32'h7);
    apb(1'b1, bbc_pkg::ADDR_VSEL_HI, 32'h55);
    en_cmd <= 1'b0;
    repeat (8) @(posedge mclk);
    chk("shutdown", reg_en, 1'b0);
    for (int i = 0; i < 3; i++) begin
      apb(1'b0, 8'(4 * i), 32'h0);
      chk("defaults back", q, rv[i]);
    end
    end_sim();
  end
endmodule : bbc_top_bench
